// >>> rtl/sac_conversion_control.sv
// SAR conversion sequencer with split three-state result outputs
`timescale 1ns/1ps

// Contract
// - Start rise resets logic, done high quickly.
// - Sequence begins on start falling edge only.
// - Trial bits MSB first down to LSB.
// - Clear trial bit when comparator says over.
// - Final result held until next conversion.
// - Done flag low after last trial.
// - Enables gate upper 8, lower 2 independently.
// - Disabled group outputs float.
// - Plain binary unipolar, offset binary bipolar.
// - Bipolar offset is MSB minus half LSB.
// - Grounded select gives unipolar mode.
// - Open select gives bipolar mode.
// - Bipolar zero input yields code 1000000000.
module sac_conversion_control (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Host control
  input  wire logic        start,
  input  wire logic        upper_byte_output_enable_n,
  input  wire logic        lower_bits_output_enable_n,
  output logic             conversion_done_n,
  // Mode select, high when the select pin is left open
  input  wire logic        bipolar_select,
  // Analog front end
  output logic [9:0]       dac_code,
  output logic             bipolar_offset_on,
  input  wire logic        comparator_over,
  // Result buses, two signals per pin group
  output logic [7:0]       upper_data_out,
  output logic [7:0]       upper_data_oe_n,
  output logic [1:0]       lower_data_out,
  output logic [1:0]       lower_data_oe_n
);

  // Registered state and its next value
  sac_pkg::sac_regs_t r_reg;
  sac_pkg::sac_regs_t r_next;

  // Start edge flags
  logic       start_rise;
  logic       start_fall;

  // Bit trial helpers
  logic       trial_window_end;
  logic       trial_last_bit;
  logic [9:0] trial_drop_mask;
  logic [9:0] trial_decided;
  logic [9:0] trial_next_mask;
  logic [3:0] wait_cnt_dec;
  logic [3:0] bit_idx_dec;

  // Previous sample resets low, matching an idle host, so no false edge after reset
  assign start_rise = start & ~r_reg.start_d;
  assign start_fall = ~start & r_reg.start_d;

  // Comparator read on the window's last cycle only, after the trial code has settled
  assign trial_window_end = (r_reg.wait_cnt == 4'h1);
  assign trial_last_bit   = (r_reg.bit_idx == 4'h0);
  assign trial_drop_mask  = comparator_over ? r_reg.trial_mask : 10'h000;
  assign trial_decided    = r_reg.result & ~trial_drop_mask;
  assign trial_next_mask  = r_reg.trial_mask >> 1;
  assign wait_cnt_dec     = r_reg.wait_cnt - 4'h1;
  assign bit_idx_dec      = r_reg.bit_idx - 4'h1;

  always_comb begin
    r_next         = r_reg;
    r_next.start_d = start;
    if (start_rise) begin
      // Any rising start aborts whatever is running
      r_next.state      = sac_pkg::SAC_ARMED;
      r_next.result     = sac_pkg::RESULT_RESET;
      r_next.trial_mask = sac_pkg::RESULT_RESET;
      r_next.done_n     = 1'b1;
    end else begin
      case (r_reg.state)
        sac_pkg::SAC_IDLE: begin
          // A lone falling start is ignored here
          r_next.state = sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_ARMED: begin
          if (start_fall) begin
            r_next.state      = sac_pkg::SAC_TRIAL;
            r_next.bit_idx    = sac_pkg::MSB_INDEX;
            r_next.trial_mask = sac_pkg::MSB_MASK;
            r_next.result     = sac_pkg::MSB_MASK;
            r_next.wait_cnt   = sac_pkg::TRIAL_CYC;
          end
        end
        sac_pkg::SAC_TRIAL: begin
          if (!trial_window_end) begin
            r_next.wait_cnt = wait_cnt_dec;
          end else begin
            // Decide current bit, then light the next lower one
            r_next.result = trial_decided;
            if (trial_last_bit) begin
              r_next.state      = sac_pkg::SAC_IDLE;
              r_next.trial_mask = sac_pkg::RESULT_RESET;
              r_next.done_n     = 1'b0;
            end else begin
              r_next.trial_mask = trial_next_mask;
              r_next.result     = trial_decided | trial_next_mask;
              r_next.bit_idx    = bit_idx_dec;
              r_next.wait_cnt   = sac_pkg::TRIAL_CYC;
            end
          end
        end
        default: begin
          r_next.state = sac_pkg::SAC_IDLE;
        end
      endcase
    end
    // Output data tracks the register, partial or final
    r_next.hi_data = r_next.result[9:2];
    r_next.lo_data = r_next.result[1:0];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_reg.state      <= sac_pkg::SAC_IDLE;
      r_reg.start_d    <= 1'b0;
      r_reg.result     <= sac_pkg::RESULT_RESET;
      r_reg.trial_mask <= sac_pkg::RESULT_RESET;
      r_reg.bit_idx    <= 4'h0;
      r_reg.wait_cnt   <= 4'h0;
      r_reg.done_n     <= 1'b1;
      r_reg.hi_data    <= 8'h00;
      r_reg.lo_data    <= 2'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Offset binary falls out of the analog offset; digital code is same in both modes
  assign bipolar_offset_on = bipolar_select;
  assign dac_code          = r_reg.result;
  assign conversion_done_n = r_reg.done_n;

  // Per-pin data and enable; enables act at once, even mid-conversion
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_pin
      if (gi >= 2) begin : g_upper
        assign upper_data_out[gi - 2]  = r_reg.hi_data[gi - 2];
        assign upper_data_oe_n[gi - 2] = upper_byte_output_enable_n;
      end else begin : g_lower
        assign lower_data_out[gi]  = r_reg.lo_data[gi];
        assign lower_data_oe_n[gi] = lower_bits_output_enable_n;
      end
    end
  endgenerate

endmodule : sac_conversion_control

// >>> shared/sac_pkg.sv
// Package holding constants and types for the SAR conversion control block
package sac_pkg;

  localparam int unsigned RES_BITS        = 10;
  localparam int unsigned HI_BITS         = 8;
  localparam int unsigned LO_BITS         = 2;

  // Reference clock
  localparam int unsigned CLK_PERIOD_NS   = 50;

  // Latest moment for done flag rise after start rising edge
  localparam int unsigned DONE_RISE_MAX_NS = 1500;
  localparam int unsigned DONE_RISE_MAX_CYC =
    (DONE_RISE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (DONE_RISE_MAX_NS / CLK_PERIOD_NS);

  // Least start pulse width the host must give
  localparam int unsigned START_MIN_NS    = 500;
  localparam int unsigned START_MIN_CYC   = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles spent per bit trial, lets the comparator settle
  localparam logic [3:0]  TRIAL_CYC       = 4'h2;

  localparam logic [9:0]  RESULT_RESET    = 10'h000;
  localparam logic [9:0]  MSB_MASK        = 10'h200;
  localparam logic [3:0]  MSB_INDEX       = 4'h9;

  typedef enum logic [2:0] {
    SAC_IDLE  = 3'b001,
    SAC_ARMED = 3'b010,
    SAC_TRIAL = 3'b100
  } sac_state_t;

  typedef struct packed {
    sac_state_t  state;
    logic        start_d;
    logic [9:0]  result;
    logic [9:0]  trial_mask;
    logic [3:0]  bit_idx;
    logic [3:0]  wait_cnt;
    logic        done_n;
    logic [7:0]  hi_data;
    logic [1:0]  lo_data;
  } sac_regs_t;

endpackage : sac_pkg

// >>> tb/sac_cmp_model.sv
// Comparator stand-in: target code plays the analog input
`timescale 1ns/1ps
module sac_cmp_model (
  // Trial side
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] target,
  // Decision
  output logic            comparator_over
);
  assign comparator_over = dac_code > target;
endmodule : sac_cmp_model

// >>> tb/sac_monitor.sv
// Checker of sequencing and output gating
`timescale 1ns/1ps
module sac_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Host side
  input wire logic       start,
  input wire logic       upper_byte_output_enable_n,
  input wire logic       lower_bits_output_enable_n,
  input wire logic       bipolar_select,
  // Watched outputs
  input wire logic       conversion_done_n,
  input wire logic       bipolar_offset_on,
  input wire logic [9:0] dac_code,
  input wire logic [7:0] upper_data_oe_n,
  input wire logic [1:0] lower_data_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  done_rise_a: assert property ($rose(start) |=> conversion_done_n && dac_code == 10'h000)
    else $error("no reset on start");
  armed_hold_a: assert property ($past(start) && start |-> dac_code == 10'h000) else $error("early trial");
  msb_first_a: assert property ($fell(start) |=> dac_code == 10'h200) else $error("MSB not first");
  done_time_a: assert property ($fell(start) ##1 (!start)[*8] ##1 (!start)[*8] ##1 (!start)[*4]
    |=> !conversion_done_n) else $error("done late");
  result_hold_a: assert property (!conversion_done_n && !start |=> !conversion_done_n && $stable(dac_code))
    else $error("result moved");
  upper_oe_a: assert property (upper_data_oe_n == {8{upper_byte_output_enable_n}}) else $error("upper oe");
  lower_oe_a: assert property (lower_data_oe_n == {2{lower_bits_output_enable_n}}) else $error("lower oe");
  offset_sel_a: assert property (bipolar_offset_on == bipolar_select) else $error("offset select");
endmodule : sac_monitor

bind sac_conversion_control sac_monitor u_mon (.*);

// >>> tb/tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, resetn, start, bipolar_select, comparator_over, conversion_done_n, bipolar_offset_on;
  logic        upper_byte_output_enable_n, lower_bits_output_enable_n;
  logic [9:0]  dac_code, target;
  logic [7:0]  upper_data_out, upper_data_oe_n;
  logic [1:0]  lower_data_out, lower_data_oe_n;
  int          num_errors = 0, compares = 0;
  // Rows are {bipolar_select, analog target}; result equals target
  logic [10:0] rows [5] = '{11'h000, 11'h3FF, 11'h600, 11'h155, 11'h6AA};
  sac_conversion_control DUT (.*);
  sac_cmp_model u_cmp (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(logic [9:0] seen, logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic launch(logic [9:0] t);
    @(posedge ref_clk);
    {upper_byte_output_enable_n, lower_bits_output_enable_n} <= 2'b11;
    target <= t;
    start <= 1'b1;
    repeat (10) @(posedge ref_clk);
    start <= 1'b0;
  endtask : launch
  task automatic finish_conv(logic [9:0] t);
    #1;
    for (int i = 0; i < 40 && conversion_done_n !== 1'b0; i++) @(posedge ref_clk) #1;
    chk({9'h000, conversion_done_n}, 10'h000);
    @(posedge ref_clk);
    {upper_byte_output_enable_n, lower_bits_output_enable_n} <= 2'b00;
    @(posedge ref_clk) #1;
    chk({upper_data_oe_n, lower_data_oe_n}, 10'h000);
    chk({upper_data_out, lower_data_out}, t);
  endtask : finish_conv
  initial begin
    {resetn, start, bipolar_select, target} = '0;
    {upper_byte_output_enable_n, lower_bits_output_enable_n} = 2'b11;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({conversion_done_n, dac_code[8:0]}, 10'h200);
    chk({upper_data_oe_n, lower_data_oe_n}, 10'h3FF);
    $display("reset test done");
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bipolar_select <= rows[i][10];
      launch(rows[i][9:0]);
      finish_conv(rows[i][9:0]);
      chk({9'h000, bipolar_offset_on}, {9'h000, rows[i][10]});
      $display("row %0d done", i);
    end
    // Restart lands mid-trial, old partial code must not leak
    launch(10'h0F0);
    repeat (5) @(posedge ref_clk);
    launch(10'h30F);
    finish_conv(10'h30F);
    $display("abort test done");
    end_sim;
  end
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
endmodule : tb_top
